// ---- verilog/adc_seq_pkg.sv ----
/*
 * Constants, register layout and types for the conversion sequencer.
 * Assumes a single 20 MHz clock and a classic Wishbone register bus.
 */
// Function
// - Clock select: osc/2, /8, /32, RC
// - Channel field picks one of four inputs
// - Go bit starts conversion, clears when done
// - Pin config field sets analog/digital pins
// - Odd codes below 111 use pin reference
// - Pin config resets to all analog
// - Analog pins read as zero
// - Completion loads result, clears go, flags
// - Eight-bit successive approximation result
// - Two-period recovery wait, capacitor disconnected
// - Converter keeps running in sleep on RC clock
// - RC clock: delay, wake if enabled
// - Sleep aborts non-RC conversion, power down
// - Clearing go aborts, result kept, rewait
// - Conversion takes nine and half periods
package adc_seq_pkg;

	//--------------------------------------------------------------
	// Register word indices (byte address is index times four)
	//--------------------------------------------------------------
	localparam logic [7:0] IDX_MAIN_CTRL   = 8'h1f;
	localparam logic [7:0] IDX_PIN_CFG     = 8'h9f;
	localparam logic [7:0] IDX_RESULT      = 8'h1e;
	localparam logic [7:0] IDX_INT_STATUS  = 8'h20;
	localparam logic [7:0] IDX_INT_MASK    = 8'h21;
	localparam logic [7:0] IDX_PORT_IN     = 8'h22;
	localparam logic [7:0] IDX_SLEEP_CTRL  = 8'h23;

	//--------------------------------------------------------------
	// Field positions
	//--------------------------------------------------------------
	localparam int CLK_SEL_LSB = 6;
	localparam int CHAN_LSB    = 3;
	localparam int GO_BIT      = 2;
	localparam int POWER_BIT   = 0;
	localparam int DONE_STAT   = 0;

	//--------------------------------------------------------------
	// Reset values and codes
	//--------------------------------------------------------------
	localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
	localparam logic [2:0] PIN_CFG_RST   = 3'h0;
	localparam logic [1:0] CLK_RC        = 2'h3;

	//--------------------------------------------------------------
	// Timing: periods in half-periods, RC clock period in ns
	//--------------------------------------------------------------
	localparam int CLK_NS        = 50;
	localparam int RC_TAD_NS     = 4000;
	localparam int RC_TAD_CYC    = RC_TAD_NS / CLK_NS;
	localparam int INSTR_NS      = 1000;
	localparam int INSTR_CYC     = INSTR_NS / CLK_NS;
	localparam int HALF_OSC2     = 1;
	localparam int HALF_OSC8     = 4;
	localparam int HALF_OSC32    = 16;
	localparam int CONV_HALVES   = 19;
	localparam int RECOV_HALVES  = 4;

	typedef enum {
		ST_IDLE,
		ST_DELAY,
		ST_CONVERT,
		ST_RECOVER
	} seq_state_t;

	// Current-state view of the main control fields
	typedef struct packed {
		logic [1:0] clk_sel;
		logic [1:0] chan;
		logic       go;
		logic       power;
	} ctrl_view_t;

endpackage

// ---- verilog/tad_tick_gen.sv ----
/*
 * Half-period tick generator for the bit conversion period.
 * Assumes it runs on the system clock; restarts when clear is high.
 */
module tad_tick_gen
	import adc_seq_pkg::*;
#(
	parameter int RC_CYC = RC_TAD_CYC
) (
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic       clear,
	input  wire logic [1:0] conv_clock_select,
	output logic            half_tick
);
	logic [9:0] cnt_r;
	logic [9:0] limit;

	// Half period in system clocks per selected source
	always_comb begin
		case (conv_clock_select)
			2'h0:    limit = 10'(HALF_OSC2);
			2'h1:    limit = 10'(HALF_OSC8);
			2'h2:    limit = 10'(HALF_OSC32);
			default: limit = 10'((RC_CYC + 1) / 2);
		endcase
	end

	assign half_tick = (cnt_r + 10'h001 >= limit) && !clear;

	// Free count restarted on each tick or on clear
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r <= 10'h000;
		end else if (clear || half_tick) begin
			cnt_r <= 10'h000;
		end else begin
			cnt_r <= cnt_r + 10'h001;
		end
	end
endmodule // tad_tick_gen

// ---- verilog/adc_conversion_sequencer.sv ----
/*
 * Conversion sequencer: registers, successive approximation control,
 * pin configuration and sleep handling. Assumes a Wishbone classic
 * master and an external comparator answering the trial code.
 */
module adc_conversion_sequencer
	import adc_seq_pkg::*;
#(
	parameter int RC_CYC = RC_TAD_CYC
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [3:0]  pin_level,
	input  wire logic        sleep_req,
	input  wire logic        cmp_above,
	output logic      [7:0]  sar_trial,
	output logic      [1:0]  input_channel_select,
	output logic             holding_capacitor,
	output logic             use_pin_reference,
	output logic      [3:0]  analog_pin_mask,
	output logic             converter_active,
	output logic             wake_core,
	output logic             irq
);
	//--------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------
	logic [7:0]  ctrl_r;
	logic [2:0]  pin_config_field;
	logic [7:0]  conversion_result;
	logic        conversion_done_flag;
	logic        conversion_done_int_enable;
	logic [7:0]  sar_r;
	logic [3:0]  bitmask_r;
	logic [4:0]  half_cnt_r;
	logic [4:0]  dly_r;
	logic [2:0]  sync1_r, sync2_r, sync3_r;
	logic [3:0]  pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
	logic        wb_ack_r;
	logic        sleeping_r;
	seq_state_t  state_r;
	ctrl_view_t  cv;
	logic        half_tick;
	logic        tick_clear;
	logic        wr, rd;
	logic [7:0]  adr;
	logic        done_evt;
	logic        abort_sw;
	logic        conv_abort;
	logic        go_wr;
	logic        go_clr_wr;

	assign cv = '{clk_sel: ctrl_r[CLK_SEL_LSB +: 2],
		chan: ctrl_r[CHAN_LSB +: 2],
		go: ctrl_r[GO_BIT], power: ctrl_r[POWER_BIT]};
	assign adr = wb_adr_i[9:2];
	assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_r && wb_sel_i[0];
	assign rd  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_r;
	assign go_wr     = wr && adr == IDX_MAIN_CTRL && wb_dat_i[GO_BIT];
	assign go_clr_wr = wr && adr == IDX_MAIN_CTRL && !wb_dat_i[GO_BIT];

	// Pin modes per configuration code: bit set means analog input
	function automatic logic [3:0] analog_of(input logic [2:0] cfg);
		case (cfg)
			3'h0:    analog_of = 4'hf;
			3'h1:    analog_of = 4'hd;
			3'h2:    analog_of = 4'h7;
			3'h3:    analog_of = 4'h5;
			3'h4:    analog_of = 4'h3;
			3'h5:    analog_of = 4'h1;
			3'h6:    analog_of = 4'h1;
			default: analog_of = 4'h0;
		endcase
	endfunction

	assign analog_pin_mask   = analog_of(pin_config_field);
	// Odd codes below seven steal pin 1 as reference
	assign use_pin_reference = pin_config_field[0] && pin_config_field != 3'h7;
	assign input_channel_select = cv.chan;

	//--------------------------------------------------------------
	// Tick generator, restarted outside active timing states
	//--------------------------------------------------------------
	assign tick_clear = state_r == ST_IDLE || state_r == ST_DELAY
		|| conv_abort; // Recovery after abort gets full periods

	tad_tick_gen #(.RC_CYC(RC_CYC)) u_tick (
		.clock            (clock),
		.sys_rst          (sys_rst),
		.clear            (tick_clear),
		.conv_clock_select(cv.clk_sel),
		.half_tick        (half_tick)
	);

	// Pin inputs pass three stages; value moves once stages agree
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1_r <= 4'h0;
			pin_s2_r <= 4'h0;
			pin_s3_r <= 4'h0;
			pin_r    <= 4'h0;
		end else begin
			pin_s1_r <= pin_level;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			if (pin_s2_r == pin_s3_r) begin
				pin_r <= pin_s3_r;
			end
		end
	end

	// Sleep request is an outside level: same three-stage treatment
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r    <= 3'h0;
			sync2_r    <= 3'h0;
			sync3_r    <= 3'h0;
			sleeping_r <= 1'b0;
		end else begin
			sync1_r <= {2'h0, sleep_req};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			if (sync2_r[0] == sync3_r[0]) begin
				sleeping_r <= sync3_r[0];
			end
		end
	end

	wire sleep_edge = sync2_r[0] && sync3_r[0] && !sleeping_r;

	//--------------------------------------------------------------
	// Conversion state machine
	//--------------------------------------------------------------
	assign abort_sw = go_clr_wr && state_r == ST_CONVERT;
	assign conv_abort = abort_sw
		|| (state_r == ST_CONVERT && sleep_edge && cv.clk_sel != CLK_RC);
	assign done_evt = state_r == ST_CONVERT && half_tick
		&& half_cnt_r == 5'(CONV_HALVES - 1);

	// Sequence: optional RC delay, convert, recovery wait
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_r    <= ST_IDLE;
			half_cnt_r <= 5'h00;
			dly_r      <= 5'h00;
		end else begin
			case (state_r)
				ST_IDLE: begin
					half_cnt_r <= 5'h00;
					dly_r      <= 5'h00;
					if (go_wr && cv.power) begin
						state_r <= (wb_dat_i[7:6] == CLK_RC) ? ST_DELAY : ST_CONVERT;
					end
				end
				ST_DELAY: begin
					dly_r <= dly_r + 5'h01;
					if (dly_r == 5'(INSTR_CYC - 1)) begin
						state_r <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (conv_abort) begin
						state_r    <= ST_RECOVER;
						half_cnt_r <= 5'h00;
					end else if (half_tick) begin
						half_cnt_r <= half_cnt_r + 5'h01;
						if (done_evt) begin
							state_r    <= ST_RECOVER;
							half_cnt_r <= 5'h00;
						end
					end
				end
				ST_RECOVER: begin
					if (half_tick) begin
						half_cnt_r <= half_cnt_r + 5'h01;
						if (half_cnt_r == 5'(RECOV_HALVES - 1)) begin
							state_r <= ST_IDLE;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Successive approximation: one bit per full period (odd halves)
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sar_r     <= 8'h00;
			bitmask_r <= 4'h0;
		end else if (state_r != ST_CONVERT) begin
			sar_r     <= 8'h80;
			bitmask_r <= 4'h7;
		end else if (half_tick && half_cnt_r[0] && half_cnt_r < 5'h10) begin
			// Keep or drop the trial bit, then set the next one
			sar_r[bitmask_r[2:0]] <= cmp_above;
			if (bitmask_r != 4'h0) begin
				sar_r[bitmask_r[2:0] - 3'h1] <= 1'b1;
			end
			bitmask_r <= bitmask_r - 4'h1;
		end
	end

	assign sar_trial = sar_r;
	// Capacitor tracks input only while idle; isolated otherwise
	assign holding_capacitor = cv.power && state_r == ST_IDLE;
	// Non-RC sleep or idle sleep turns the analog core off
	assign converter_active = cv.power && !(sleeping_r && state_r == ST_IDLE)
		&& !(sleeping_r && cv.clk_sel != CLK_RC);

	//--------------------------------------------------------------
	// Registers written by software and updated by hardware
	//--------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_r <= MAIN_CTRL_RST;
		end else if (done_evt || conv_abort) begin
			ctrl_r[GO_BIT] <= 1'b0;
			if (wr && adr == IDX_MAIN_CTRL) begin
				ctrl_r[CLK_SEL_LSB +: 2] <= wb_dat_i[CLK_SEL_LSB +: 2];
				ctrl_r[CHAN_LSB +: 2]    <= wb_dat_i[CHAN_LSB +: 2];
				ctrl_r[POWER_BIT]        <= wb_dat_i[POWER_BIT];
			end
		end else if (wr && adr == IDX_MAIN_CTRL) begin
			// Power bit stays set through sleep abort; go only sticks
			// when a start is possible, else it would never clear
			ctrl_r <= {wb_dat_i[7:6], 1'b0, wb_dat_i[4:3],
				wb_dat_i[GO_BIT] && wb_dat_i[POWER_BIT]
				&& ctrl_r[POWER_BIT] && (state_r == ST_IDLE || cv.go),
				1'b0, wb_dat_i[POWER_BIT]};
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pin_config_field           <= PIN_CFG_RST;
			conversion_done_int_enable <= 1'b0;
		end else if (wr) begin
			if (adr == IDX_PIN_CFG) pin_config_field <= wb_dat_i[2:0];
			if (adr == IDX_INT_MASK) conversion_done_int_enable <= wb_dat_i[DONE_STAT];
		end
	end

	// Result loads on completion or software write; aborts leave it untouched
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			conversion_result <= 8'h00;
		end else if (done_evt) begin
			conversion_result <= sar_r;
		end else if (wr && adr == IDX_RESULT) begin
			conversion_result <= wb_dat_i[7:0];
		end
	end

	// Sticky flag: set wins over the read that clears it
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			conversion_done_flag <= 1'b0;
		end else if (done_evt) begin
			conversion_done_flag <= 1'b1;
		end else if (rd && adr == IDX_INT_STATUS) begin
			conversion_done_flag <= 1'b0;
		end
	end

	assign irq = conversion_done_flag && conversion_done_int_enable;
	assign wake_core = sleeping_r && irq;

	//--------------------------------------------------------------
	// Wishbone read data and ack
	//--------------------------------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_r <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_r <= wb_cyc_i && wb_stb_i && !wb_ack_r;
			if (rd) begin
				case (adr)
					IDX_MAIN_CTRL:  wb_dat_o <= {24'h0, ctrl_r};
					IDX_PIN_CFG:    wb_dat_o <= {29'h0, pin_config_field};
					IDX_RESULT:     wb_dat_o <= {24'h0, conversion_result};
					IDX_INT_STATUS: wb_dat_o <= {31'h0, conversion_done_flag};
					IDX_INT_MASK:   wb_dat_o <= {31'h0, conversion_done_int_enable};
					IDX_PORT_IN:    wb_dat_o <= {28'h0, pin_r & ~analog_pin_mask};
					default:        wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign wb_ack_o = wb_ack_r;

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	a_done_clears_go: assert property (@(posedge clock) disable iff (sys_rst)
		done_evt |=> !ctrl_r[GO_BIT] && conversion_done_flag)
		else $error("completion did not clear go or set flag");
	a_abort_keeps_result: assert property (@(posedge clock) disable iff (sys_rst)
		abort_sw |=> $stable(conversion_result))
		else $error("abort changed result");
	a_analog_read_zero: assert property (@(posedge clock) disable iff (sys_rst)
		rd && adr == IDX_PORT_IN |=> (wb_dat_o[3:0] & analog_pin_mask) == 4'h0)
		else $error("analog pin read nonzero");
	a_power_gates_go: assert property (@(posedge clock) disable iff (sys_rst)
		state_r == ST_IDLE && !cv.power |=> state_r == ST_IDLE)
		else $error("start while powered off");
	a_recover_isolates: assert property (@(posedge clock) disable iff (sys_rst)
		state_r == ST_RECOVER |-> !holding_capacitor)
		else $error("capacitor connected during recovery");
	a_cfg_reference: assert property (@(posedge clock) disable iff (sys_rst)
		pin_config_field == 3'h3 |-> use_pin_reference && !analog_pin_mask[1])
		else $error("reference pin misconfigured");
	sequence s_rc_start;
		state_r == ST_IDLE ##1 state_r == ST_DELAY;
	endsequence
	a_rc_delay: assert property (@(posedge clock) disable iff (sys_rst)
		s_rc_start |-> state_r == ST_DELAY [*8])
		else $error("rc start delay too short");
	a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
		rd && adr == IDX_INT_STATUS && !done_evt |=> !irq)
		else $error("irq stayed high after status read");
	a_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
		conversion_done_flag && !(rd && adr == IDX_INT_STATUS)
		|=> conversion_done_flag)
		else $error("done flag lost without status read");
endmodule // adc_conversion_sequencer

// ---- test/tb.sv ----
/*
 * Self-checking bench for the conversion sequencer.
 * Assumes the package is compiled first; the bench drives every port.
 */
module tb
	import adc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	//------------------------------------------------------------
	// Signals and design instance
	//------------------------------------------------------------
	logic        clock = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [9:0]  adr = 10'h000;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic [3:0]  pins = 4'hf;
	logic        slp = 1'b0;
	logic [7:0]  target = 8'h00;
	logic [7:0]  trial;
	logic [1:0]  chan;
	logic        cap, pref, act, wake, irq, cmp;
	logic [3:0]  amask;
	logic [7:0]  q;
	int          fails = 0;
	int          total_checks = 0;

	// Ideal comparator against the held analog level
	assign cmp = (target >= trial);

	adc_conversion_sequencer #(.RC_CYC(4)) dut (
		.clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .pin_level(pins), .sleep_req(slp),
		.cmp_above(cmp), .sar_trial(trial),
		.input_channel_select(chan), .holding_capacitor(cap),
		.use_pin_reference(pref), .analog_pin_mask(amask),
		.converter_active(act), .wake_core(wake), .irq(irq)
	);

	initial forever #25 clock = ~clock;

	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string m);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	// Classic cycle; request held until ack is sampled high at a rise
	task automatic bus(input logic w, input logic [7:0] idx,
			input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			$display("unexpected at %0t: no bus answer", $time);
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic t_reset;
		bus(1'b0, IDX_MAIN_CTRL, 8'h00);
		chk(q, 8'h00, "main control reset");
		bus(1'b0, IDX_PIN_CFG, 8'h00);
		chk(q, 8'h00, "pin config reset");
		chk({4'h0, amask}, 8'h0f, "pins not analog after reset");
		bus(1'b1, IDX_PIN_CFG, 8'hff);
		bus(1'b0, IDX_PIN_CFG, 8'h00);
		chk(q, 8'h07, "pin config upper bits");
	endtask

	// Every pin code: analog set, reference source, port read-back
	task automatic t_pins;
		logic [3:0] am[8] = '{4'hf, 4'hd, 4'h7, 4'h5,
			4'h3, 4'h1, 4'h1, 4'h0};
		logic [3:0] cm;
		logic       r;
		for (int c = 0; c < 8; c++) begin
			r = (c == 1 || c == 3 || c == 5);
			cm = r ? 4'hd : 4'hf;
			bus(1'b1, IDX_PIN_CFG, 8'(c));
			repeat (5) @(posedge clock);
			chk({4'h0, amask & cm}, {4'h0, am[c] & cm}, "pin mask");
			chk({7'h0, pref}, {7'h0, r}, "reference select");
			bus(1'b0, IDX_PORT_IN, 8'h00);
			chk(q & {4'h0, cm}, {4'h0, ~am[c] & cm}, "port read");
		end
		bus(1'b1, IDX_PIN_CFG, 8'h00);
	endtask

	task automatic t_chan;
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, IDX_MAIN_CTRL, {3'h0, 2'(c), 3'h1});
			chk({6'h0, chan}, 8'(c), "channel select");
		end
	endtask

	// One conversion: duration, recovery isolation, result, flag
	task automatic t_conv(input logic [1:0] code, input logic [7:0] tgt,
			input int halves, input int dly, input logic s);
		int n;
		int e;
		n = 0;
		e = CONV_HALVES * halves + dly;
		target <= tgt;
		slp <= s;
		bus(1'b1, IDX_MAIN_CTRL, {code, 6'h01});
		// Longest recovery (4 x 16 clocks) plus acquisition settling
		repeat (80) @(posedge clock);
		bus(1'b1, IDX_MAIN_CTRL, {code, 6'h05});
		do begin
			@(negedge clock);
			n++;
		end while (irq !== 1'b1 && n < e + 40);
		chk(8'(n >= e - 3 && n <= e + halves + 2), 8'h01,
			"conversion length");
		chk({7'h0, cap}, 8'h00, "capacitor connected in recovery");
		if (s) begin
			chk({7'h0, wake}, 8'h01, "no wake after sleep conversion");
			chk({7'h0, act}, 8'h01, "converter off in sleep");
		end
		bus(1'b0, IDX_MAIN_CTRL, 8'h00);
		chk(q & 8'h05, 8'h01, "go or power after done");
		bus(1'b0, IDX_RESULT, 8'h00);
		chk(q, tgt, "conversion result");
		bus(1'b0, IDX_INT_STATUS, 8'h00);
		chk(q & 8'h01, 8'h01, "done flag");
		bus(1'b0, IDX_INT_STATUS, 8'h00);
		chk(q & 8'h01, 8'h00, "flag not cleared by read");
		chk({7'h0, irq}, 8'h00, "irq after clear");
		slp <= 1'b0;
	endtask

	task automatic t_mask;
		target <= 8'he7;
		bus(1'b1, IDX_INT_MASK, 8'h00);
		bus(1'b1, IDX_MAIN_CTRL, 8'h01);
		bus(1'b1, IDX_MAIN_CTRL, 8'h05);
		repeat (40) @(posedge clock);
		chk({7'h0, irq}, 8'h00, "masked irq raised");
		bus(1'b1, IDX_INT_MASK, 8'h01);
		chk({7'h0, irq}, 8'h01, "unmasked irq low");
		bus(1'b0, IDX_INT_STATUS, 8'h00);
		chk({7'h0, irq}, 8'h00, "irq stuck");
	endtask

	// Software abort on a slow clock keeps the old result
	task automatic t_abort(input logic [7:0] old);
		target <= 8'h5a;
		bus(1'b1, IDX_MAIN_CTRL, 8'h81);
		bus(1'b1, IDX_MAIN_CTRL, 8'h85);
		bus(1'b0, IDX_MAIN_CTRL, 8'h00);
		chk(q & 8'h04, 8'h04, "go not busy");
		bus(1'b1, IDX_MAIN_CTRL, 8'h81);
		chk({7'h0, cap}, 8'h00, "capacitor connected after abort");
		repeat (400) @(posedge clock);
		bus(1'b0, IDX_RESULT, 8'h00);
		chk(q, old, "result changed by abort");
		bus(1'b0, IDX_INT_STATUS, 8'h00);
		chk(q, 8'h00, "flag after abort");
		chk({7'h0, cap}, 8'h01, "no acquisition after abort");
	endtask

	task automatic t_sleep(input logic [7:0] old);
		target <= 8'h5a;
		bus(1'b1, IDX_MAIN_CTRL, 8'h81);
		bus(1'b1, IDX_MAIN_CTRL, 8'h85);
		repeat (20) @(posedge clock);
		slp <= 1'b1;
		repeat (400) @(posedge clock);
		chk({7'h0, act}, 8'h00, "converter on after sleep abort");
		bus(1'b0, IDX_MAIN_CTRL, 8'h00);
		chk(q & 8'h05, 8'h01, "sleep abort go or power");
		bus(1'b0, IDX_RESULT, 8'h00);
		chk(q, old, "result changed by sleep");
		slp <= 1'b0;
	endtask

	task automatic t_power;
		bus(1'b1, IDX_MAIN_CTRL, 8'h00);
		bus(1'b1, IDX_MAIN_CTRL, 8'h04);
		repeat (40) @(posedge clock);
		chk({7'h0, irq}, 8'h00, "conversion while off");
		chk({7'h0, act}, 8'h00, "converter active while off");
		bus(1'b0, IDX_INT_STATUS, 8'h00);
		chk(q, 8'h00, "flag while off");
		bus(1'b0, IDX_MAIN_CTRL, 8'h00);
		chk(q, 8'h00, "go set while off");
		bus(1'b1, IDX_RESULT, 8'h3c);
		bus(1'b0, IDX_RESULT, 8'h00);
		chk(q, 8'h3c, "written result lost");
	endtask

	//------------------------------------------------------------
	// Main sequence and watchdog
	//------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset;
		t_pins;
		t_chan;
		bus(1'b1, IDX_INT_MASK, 8'h01);
		t_conv(2'h0, 8'ha5, 1, 0, 1'b0);
		t_conv(2'h1, 8'h3c, 4, 0, 1'b0);
		t_conv(2'h2, 8'hff, 16, 0, 1'b0);
		t_conv(CLK_RC, 8'h00, 2, INSTR_CYC, 1'b1);
		t_mask;
		t_abort(8'he7);
		t_sleep(8'he7);
		t_power;
		stop_test;
	end

	// Limit well beyond the few thousand cycles the scenarios need
	initial begin
		#500000;
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		stop_test;
	end

endmodule // tb
